/* rtl/tcto_ctrl.sv */
// Timer run control, update-event gating, reload buffer and trigger out.
// Assumes an AXI4-Lite master and counter, slave and channel logic on
// the same timer clock; their event inputs are one-cycle pulses.
// Functional notes
// - Trigger operation lets hardware set run enable with no software write.
// - With reload buffer on, each update event loads the buffered reload value; the divide code applies at once.
// - Inhibit clear: wrap, force bit or slave update make an update event.
// - Request source one: only counter wrap raises an update request.
// - One-shot: an update event clears run enable unless a trigger start sets it in the same cycle.
// - Reload buffer off: writes apply at once; on: at next update event.
// - Sample period divide: one, two or four clocks; code 11 reserved.
// - Trigger select 000 reset, 001 run enable, 010 update event.
// - Trigger select 011 pulses when a channel match flag gets set.
// - Trigger select 100 to 111 route compare reference of channel 1 to 4.
// - Trigger operation: rising trigger input edge starts the counter.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tcto_ctrl import tcto_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic counter_wrap,
  input wire logic slave_update,
  input wire logic counter_reset,
  input wire logic trigger_input,
  input wire logic [3:0] channel_match_set,
  input wire logic [3:0] compare_reference,
  output logic counter_run_enable,
  output logic update_event,
  output logic update_request,
  output logic [15:0] reload_active,
  output logic [2:0] slave_function_select,
  output logic filter_sample_tick,
  output logic trigger_output,
  output logic irq
);
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [1:0] wstrb_reg, wstrb_next;
  logic [2:0] wbits_reg, wbits_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] ctrl1_reg, ctrl1_next, ctrl2_reg, ctrl2_next;
  logic [2:0] slave_reg, slave_next;
  logic [15:0] reload_buf_reg, reload_buf_next;
  logic [15:0] reload_act_reg, reload_act_next;
  logic [STATUS_W-1:0] status_reg, status_next, mask_reg, mask_next;
  logic [STATUS_W-1:0] events;
  logic trig_prev_reg, trig_prev_next;
  logic ue_reg, ue_next, req_reg, req_next, trg_reg, trg_next;
  logic do_write, force_upd, reload_wr, trig_rise, trig_start;
  logic ue_now, req_now, one_shot_stop;
  logic [15:0] reload_wr_val;
  logic [2:0] tsel;
  tcto_sample_if sif ();

  assign tsel = ctrl2_reg[TSEL_LSB +: 3];
  assign trig_rise = trigger_input && !trig_prev_reg;
  assign trig_start = (slave_reg == SFS_TRIGGER) && trig_rise;
  assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
  assign force_upd = do_write && (awaddr_reg == OFF_EVENT) &&
                     wstrb_reg[0] && wdata_reg[BIT_FORCE];
  assign reload_wr = do_write && (awaddr_reg == OFF_RELOAD);
  assign reload_wr_val = merge16(reload_buf_reg, wdata_reg, wstrb_reg);
  assign ue_now = !ctrl1_reg[BIT_INHIBIT] &&
                  (counter_wrap || force_upd || slave_update);
  assign req_now = ue_now && (!ctrl1_reg[BIT_URS] || counter_wrap);
  assign one_shot_stop = ue_now && ctrl1_reg[BIT_ONE_SHOT];
  assign events = {one_shot_stop, trig_start, req_now};

  always_comb begin
    aw_have_next = aw_have_reg;
    awaddr_next = awaddr_reg;
    w_have_next = w_have_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    wbits_next = wbits_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    slave_next = slave_reg;
    reload_buf_next = reload_buf_reg;
    reload_act_next = reload_act_reg;
    status_next = status_reg;
    mask_next = mask_reg;
    trig_prev_next = trigger_input;
    if (s_axi_awvalid && !aw_have_reg) begin
      aw_have_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_reg) begin
      w_have_next = 1'b1;
      wdata_next = s_axi_wdata[15:0];
      wstrb_next = s_axi_wstrb[1:0];
      wbits_next = s_axi_wdata[2:0];
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // Update event reloads the active copy before any write lands
    if (ue_now && ctrl1_reg[BIT_RELOAD_BUF]) begin
      reload_act_next = reload_buf_reg;
    end
    if (do_write) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      if (awaddr_reg == OFF_CTRL1) begin
        ctrl1_next = merge16(ctrl1_reg, wdata_reg, wstrb_reg) &
                     CTRL1_MASK;
      end else if (awaddr_reg == OFF_CTRL2) begin
        ctrl2_next = merge16(ctrl2_reg, wdata_reg, wstrb_reg) &
                     CTRL2_MASK;
      end else if (awaddr_reg == OFF_RELOAD) begin
        reload_buf_next = reload_wr_val;
        if (!ctrl1_reg[BIT_RELOAD_BUF]) begin
          reload_act_next = reload_wr_val;
        end
      end else if (awaddr_reg == OFF_STATUS) begin
        if (wstrb_reg[0]) begin
          status_next = status_reg & ~wbits_reg;
        end
      end else if (awaddr_reg == OFF_MASK) begin
        if (wstrb_reg[0]) begin
          mask_next = wbits_reg;
        end
      end else if (awaddr_reg == OFF_SLAVE) begin
        if (wstrb_reg[0]) begin
          slave_next = wbits_reg;
        end
      end else if (awaddr_reg != OFF_EVENT &&
                   awaddr_reg != OFF_RELOAD_ACT) begin
        bresp_next = RESP_SLVERR;
      end
    end
    // Hardware wins over a software write in the same cycle
    if (one_shot_stop) begin
      ctrl1_next[BIT_RUN] = 1'b0;
    end
    if (trig_start) begin
      ctrl1_next[BIT_RUN] = 1'b1;
    end
    status_next = status_next | events;
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      if (s_axi_araddr == OFF_CTRL1) begin
        rdata_next = ctrl1_reg;
      end else if (s_axi_araddr == OFF_CTRL2) begin
        rdata_next = ctrl2_reg;
      end else if (s_axi_araddr == OFF_RELOAD) begin
        rdata_next = reload_buf_reg;
      end else if (s_axi_araddr == OFF_RELOAD_ACT) begin
        rdata_next = reload_act_reg;
      end else if (s_axi_araddr == OFF_EVENT) begin
        rdata_next = 16'h0000;
      end else if (s_axi_araddr == OFF_STATUS) begin
        rdata_next = {13'h0000, status_reg};
      end else if (s_axi_araddr == OFF_MASK) begin
        rdata_next = {13'h0000, mask_reg};
      end else if (s_axi_araddr == OFF_SLAVE) begin
        rdata_next = {13'h0000, slave_reg} & SLAVE_MASK;
      end else begin
        rdata_next = 16'h0000;
        rresp_next = RESP_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    ue_next = ue_now;
    req_next = req_now;
    case (tsel)
      TSEL_RESET: trg_next = counter_reset;
      TSEL_ENABLE: trg_next = ctrl1_reg[BIT_RUN];
      TSEL_UPDATE: trg_next = ue_now;
      TSEL_MATCH: trg_next = |channel_match_set;
      default: trg_next = compare_reference[tsel[1:0]];
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_have_reg <= 1'b0;
      wdata_reg <= 16'h0000;
      wstrb_reg <= 2'h0;
      wbits_reg <= 3'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 16'h0000;
      ctrl1_reg <= CTRL1_RESET;
      ctrl2_reg <= CTRL2_RESET;
      slave_reg <= SLAVE_RESET;
      reload_buf_reg <= RELOAD_RESET;
      reload_act_reg <= RELOAD_RESET;
      status_reg <= 3'h0;
      mask_reg <= 3'h0;
      trig_prev_reg <= 1'b0;
      ue_reg <= 1'b0;
      req_reg <= 1'b0;
      trg_reg <= 1'b0;
    end else begin
      aw_have_reg <= aw_have_next;
      awaddr_reg <= awaddr_next;
      w_have_reg <= w_have_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      wbits_reg <= wbits_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      slave_reg <= slave_next;
      reload_buf_reg <= reload_buf_next;
      reload_act_reg <= reload_act_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      trig_prev_reg <= trig_prev_next;
      ue_reg <= ue_next;
      req_reg <= req_next;
      trg_reg <= trg_next;
    end
  end

  assign sif.divide = ctrl1_reg[DIV_LSB +: 2];
  tcto_sample_div u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .sif(sif)
  );

  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready = !w_have_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = {16'h0000, rdata_reg};
  assign counter_run_enable = ctrl1_reg[BIT_RUN];
  // One cycle late, so prescaler and compare loads see a clean strobe
  assign update_event = ue_reg;
  assign update_request = req_reg;
  assign reload_active = reload_act_reg;
  assign slave_function_select = slave_reg;
  assign filter_sample_tick = sif.tick;
  assign trigger_output = trg_reg;
  assign irq = |(status_reg & mask_reg);

  property p_update_on_wrap;
    @(posedge clk_sys) disable iff (rst)
      (!ctrl1_reg[BIT_INHIBIT] && counter_wrap) |=> update_event;
  endproperty
  a_update_on_wrap: assert property (p_update_on_wrap)
    else $error("wrap did not give an update event");

  property p_inhibit;
    @(posedge clk_sys) disable iff (rst)
      ctrl1_reg[BIT_INHIBIT] |=> !update_event;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("update event while inhibited");

  property p_req_source;
    @(posedge clk_sys) disable iff (rst)
      (ctrl1_reg[BIT_URS] && !counter_wrap) |=> !update_request;
  endproperty
  a_req_source: assert property (p_req_source)
    else $error("update request from a non-wrap source");

  property p_one_shot;
    @(posedge clk_sys) disable iff (rst)
      (ue_now && ctrl1_reg[BIT_ONE_SHOT] && !trig_start)
        |=> !counter_run_enable;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("one-shot did not stop the counter");

  property p_trig_start;
    @(posedge clk_sys) disable iff (rst)
      (slave_function_select == SFS_TRIGGER && !trigger_input
       ##1 slave_function_select == SFS_TRIGGER && trigger_input)
        |=> counter_run_enable;
  endproperty
  a_trig_start: assert property (p_trig_start)
    else $error("trigger edge did not start the counter");

  property p_reload_now;
    @(posedge clk_sys) disable iff (rst)
      (reload_wr && !ctrl1_reg[BIT_RELOAD_BUF])
        |=> reload_active == $past(reload_wr_val);
  endproperty
  a_reload_now: assert property (p_reload_now)
    else $error("unbuffered reload write not applied");

  property p_reload_buffered;
    @(posedge clk_sys) disable iff (rst)
      (ue_now && ctrl1_reg[BIT_RELOAD_BUF])
        |=> reload_active == $past(reload_buf_reg) && update_event;
  endproperty
  a_reload_buffered: assert property (p_reload_buffered)
    else $error("update event did not load the reload value");

  property p_trg_enable;
    @(posedge clk_sys) disable iff (rst)
      (tsel == TSEL_ENABLE) |=> trigger_output == $past(counter_run_enable);
  endproperty
  a_trg_enable: assert property (p_trg_enable)
    else $error("trigger output does not follow run enable");

  property p_trg_match;
    @(posedge clk_sys) disable iff (rst)
      (tsel == TSEL_MATCH && |channel_match_set) |=> trigger_output;
  endproperty
  a_trg_match: assert property (p_trg_match)
    else $error("no trigger pulse on channel match");

  property p_trg_ref;
    @(posedge clk_sys) disable iff (rst)
      tsel[2] |=> trigger_output == $past(compare_reference[tsel[1:0]]);
  endproperty
  a_trg_ref: assert property (p_trg_ref)
    else $error("trigger output does not follow compare reference");

  property p_reserved;
    @(posedge clk_sys) disable iff (rst)
      (s_axi_arvalid && s_axi_arready &&
       (s_axi_araddr == OFF_CTRL1 || s_axi_araddr == OFF_CTRL2))
        |=> (s_axi_rdata[15:0] & ~($past(s_axi_araddr) == OFF_CTRL1 ?
             CTRL1_MASK : CTRL2_MASK)) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bit is set");
endmodule
`default_nettype wire

/* rtl/tcto_pkg.sv */
// Package for the timer control and trigger-out block.
// Assumes AXI4-Lite byte addresses of 8 bits and 16-bit registers in the
// low half of each 32-bit word.
package tcto_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_RELOAD = 8'h08;
  localparam logic [7:0] OFF_RELOAD_ACT = 8'h0c;
  localparam logic [7:0] OFF_EVENT = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_MASK = 8'h18;
  localparam logic [7:0] OFF_SLAVE = 8'h1c;

  // timer_control_one fields
  localparam int BIT_RUN = 0;
  localparam int BIT_INHIBIT = 1;
  localparam int BIT_URS = 2;
  localparam int BIT_ONE_SHOT = 3;
  localparam int BIT_RELOAD_BUF = 7;
  localparam int DIV_LSB = 8;
  // master_trigger_control field
  localparam int TSEL_LSB = 4;
  // Event register: update_force_bit
  localparam int BIT_FORCE = 0;
  // Status and mask layout
  localparam int ST_UPDATE = 0;
  localparam int ST_TRIG_START = 1;
  localparam int ST_ONE_SHOT = 2;
  localparam int STATUS_W = 3;

  localparam logic [15:0] CTRL1_MASK = 16'h038f;
  localparam logic [15:0] CTRL2_MASK = 16'h0070;
  localparam logic [15:0] SLAVE_MASK = 16'h0007;
  localparam logic [15:0] CTRL1_RESET = 16'h0000;
  localparam logic [15:0] CTRL2_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [2:0] SLAVE_RESET = 3'h0;

  localparam logic [2:0] SFS_TRIGGER = 3'h6;
  localparam logic [2:0] TSEL_RESET = 3'h0;
  localparam logic [2:0] TSEL_ENABLE = 3'h1;
  localparam logic [2:0] TSEL_UPDATE = 3'h2;
  localparam logic [2:0] TSEL_MATCH = 3'h3;
  localparam logic [1:0] DIV_ONE = 2'h0;
  localparam logic [1:0] DIV_TWO = 2'h1;
  localparam logic [1:0] DIV_FOUR = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Byte-lane merge of a 16-bit register with bus write data
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0] strb);
    merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
               strb[0] ? new_v[7:0] : old_v[7:0]};
  endfunction
endpackage

/* rtl/tcto_sample_div.sv */
// Divider giving one tick per filter sampling period.
// Assumes the divide code comes straight from the control register.
`timescale 1ns/1ps
`default_nettype none
module tcto_sample_div import tcto_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst,
  tcto_sample_if.div sif
);
  logic [1:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;
  logic [1:0] limit;

  // Reserved code 11 falls back to one clock per period
  always_comb begin
    if (sif.divide == DIV_TWO) begin
      limit = 2'h1;
    end else if (sif.divide == DIV_FOUR) begin
      limit = 2'h3;
    end else begin
      limit = 2'h0;
    end
    if (cnt_reg >= limit) begin
      cnt_next = 2'h0;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 2'h1;
      tick_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= 2'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign sif.tick = tick_reg;

  property p_div_one;
    @(posedge clk_sys) disable iff (rst)
      (sif.divide == DIV_ONE) [*2] |=> sif.tick;
  endproperty
  a_div_one: assert property (p_div_one)
    else $error("sample tick missing at divide by one");

  property p_div_two;
    @(posedge clk_sys) disable iff (rst)
      (sif.tick && sif.divide == DIV_TWO) |=> !sif.tick;
  endproperty
  a_div_two: assert property (p_div_two)
    else $error("sample tick too often at divide by two");
endmodule
`default_nettype wire

/* rtl/tcto_sample_if.sv */
// Link between the control block and the sampling-period divider.
// Assumes both ends run on the same timer clock.
`timescale 1ns/1ps
`default_nettype none
interface tcto_sample_if;
  logic [1:0] divide;
  logic tick;
  modport ctrl (output divide, input tick);
  modport div (input divide, output tick);
endinterface
`default_nettype wire

/* sim/tcto_ctrl_tb.sv */
// Self-checking bench for the timer control and trigger-out block.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tcto_ctrl_tb import tcto_pkg::*; ;
  logic clk_sys, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, channel_match_set, compare_reference;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic counter_wrap, slave_update, counter_reset, trigger_input;
  logic counter_run_enable, update_event, update_request;
  logic filter_sample_tick, trigger_output, irq;
  logic [15:0] reload_active, v, w;
  logic [2:0] slave_function_select;
  int mismatches = 0, total_checks = 0, ue_n = 0, ur_n = 0, tk_n = 0;
  int trig_edges, n0, n1;
  bit inh, urs;

  tcto_ctrl dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .counter_wrap,
    .slave_update, .counter_reset, .trigger_input, .channel_match_set,
    .compare_reference, .counter_run_enable, .update_event,
    .update_request, .reload_active, .slave_function_select,
    .filter_sample_tick, .trigger_output, .irq);
  tcto_slave_model slave (.clk_sys, .rst, .trigger_output,
    .edges(trig_edges));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Pulse counters update on the edge so readers see a stable value
  always @(posedge clk_sys) begin
    if (update_event === 1'b1) ue_n <= ue_n + 1;
    if (update_request === 1'b1) ur_n <= ur_n + 1;
    if (filter_sample_tick === 1'b1) tk_n <= tk_n + 1;
  end

  function automatic int exp_ur(bit i, bit u, int k);
    return int'(!i && (!u || k == 0));
  endfunction
  function automatic int exp_ticks(int c, int n);
    return c == 1 ? n / 2 : c == 2 ? n / 4 : n;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] x,
                    output logic [1:0] rr);
    bit ad, wd;
    ad = 0;
    wd = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {16'h0000, x};
    s_axi_wstrb <= 4'h3;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_sys);
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk_sys);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x,
                    output logic [1:0] rr);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    x = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wrok(input logic [7:0] a, input logic [15:0] x);
    logic [1:0] rr;
    wr(a, x, rr);
    chk("bresp", 32'(RESP_OKAY), 32'(rr));
  endtask
  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [31:0] e);
    logic [31:0] x;
    logic [1:0] rr;
    rd(a, x, rr);
    chk(n, e, x);
    chk("rresp", 32'(RESP_OKAY), 32'(rr));
  endtask
  // Event kinds: 0 wrap, 1 force, 2 slave update, 3 reset, 4 trigger
  task automatic ev(input int k);
    logic [1:0] rr;
    if (k == 1) wr(OFF_EVENT, 16'h0001, rr);
    else begin
      case (k)
        0: counter_wrap <= 1'b1;
        2: slave_update <= 1'b1;
        3: counter_reset <= 1'b1;
        default: trigger_input <= 1'b1;
      endcase
      @(posedge clk_sys);
      {counter_wrap, slave_update, counter_reset, trigger_input} <= 4'h0;
      @(posedge clk_sys);
    end
    repeat (3) @(posedge clk_sys);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    end_of_test();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {counter_wrap, slave_update, counter_reset, trigger_input} = 4'h0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    channel_match_set = 4'h0;
    compare_reference = 4'h0;
    rst = 1'b1;
    void'($urandom(29));
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdchk("ctrl1_reset", OFF_CTRL1, 32'h0);
    rdchk("ctrl2_reset", OFF_CTRL2, 32'h0);
    chk("irq_reset", 32'h0, 32'(irq));
    wrok(OFF_CTRL1, 16'hffff);
    rdchk("ctrl1_rsvd", OFF_CTRL1, 32'(CTRL1_MASK));
    wrok(OFF_CTRL2, 16'hffff);
    rdchk("ctrl2_rsvd", OFF_CTRL2, 32'(CTRL2_MASK));
    wrok(OFF_CTRL2, 16'h0000);
    wr(8'h20, 16'h1234, r);
    chk("unmapped_bresp", 32'(RESP_SLVERR), 32'(r));
    rd(8'h24, d, r);
    chk("unmapped_rdata", 32'h0, d);
    chk("unmapped_rresp", 32'(RESP_SLVERR), 32'(r));
    // Every source under every inhibit and request-source setting
    for (int c = 0; c < 12; c++) begin
      inh = c / 6;
      urs = (c / 3) % 2;
      wrok(OFF_CTRL1, 16'({urs, inh, 1'b0}));
      n0 = ue_n;
      n1 = ur_n;
      ev(c % 3);
      chk("update_event", 32'(!inh), 32'(ue_n - n0));
      chk("update_request", 32'(exp_ur(inh, urs, c % 3)), 32'(ur_n - n1));
    end
    v = 16'($urandom);
    w = v ^ 16'h5a5a;
    wrok(OFF_CTRL1, 16'h0000);
    wrok(OFF_RELOAD, v);
    rdchk("reload_direct", OFF_RELOAD_ACT, 32'(v));
    wrok(OFF_CTRL1, 16'h0080);
    wrok(OFF_RELOAD, w);
    chk("reload_held", 32'(v), 32'(reload_active));
    ev(0);
    chk("reload_loaded", 32'(w), 32'(reload_active));
    wrok(OFF_CTRL1, 16'h0009);
    chk("run_set", 32'h1, 32'(counter_run_enable));
    ev(0);
    chk("one_shot_stop", 32'h0, 32'(counter_run_enable));
    rdchk("one_shot_ctrl1", OFF_CTRL1, 32'h8);
    wrok(OFF_CTRL1, 16'h0000);
    ev(4);
    chk("no_trig_start", 32'h0, 32'(counter_run_enable));
    wrok(OFF_SLAVE, 16'(SFS_TRIGGER));
    chk("slave_sel", 32'(SFS_TRIGGER), 32'(slave_function_select));
    ev(4);
    chk("trig_start", 32'h1, 32'(counter_run_enable));
    rdchk("ctrl1_hw_set", OFF_CTRL1, 32'h1);
    rdchk("status_bits", OFF_STATUS, 32'h7);
    wrok(OFF_SLAVE, 16'h0000);
    wrok(OFF_CTRL1, 16'h0000);
    // Each trigger source gives exactly one rising edge at the slave
    for (int s = 0; s < 8; s++) begin
      wrok(OFF_CTRL2, 16'(s << TSEL_LSB));
      repeat (2) @(posedge clk_sys);
      n0 = trig_edges;
      if (s == 1) begin
        wrok(OFF_CTRL1, 16'h0001);
        wrok(OFF_CTRL1, 16'h0000);
      end else if (s == 3) begin
        channel_match_set <= 4'($urandom_range(15, 1));
        @(posedge clk_sys);
        channel_match_set <= 4'h0;
        repeat (3) @(posedge clk_sys);
      end else if (s >= 4) begin
        // Other channels move first so a wrong route shows up
        compare_reference <= 4'hf & ~(4'h1 << (s - 4));
        repeat (3) @(posedge clk_sys);
        compare_reference <= 4'hf;
        repeat (3) @(posedge clk_sys);
        compare_reference <= 4'h0;
        repeat (3) @(posedge clk_sys);
      end else ev(s == 0 ? 3 : 0);
      chk("trig_edges", 32'h1, 32'(trig_edges - n0));
    end
    wrok(OFF_CTRL2, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      wrok(OFF_CTRL1, 16'(c << DIV_LSB));
      repeat (8) @(posedge clk_sys);
      n0 = tk_n;
      repeat (40) @(posedge clk_sys);
      chk("sample_ticks", 32'(exp_ticks(c, 40)), 32'(tk_n - n0));
    end
    wrok(OFF_CTRL1, 16'h0000);
    wrok(OFF_STATUS, 16'h0007);
    wrok(OFF_MASK, 16'h0001);
    chk("irq_idle", 32'h0, 32'(irq));
    ev(1);
    chk("irq_raised", 32'h1, 32'(irq));
    rdchk("status", OFF_STATUS, 32'h1);
    wrok(OFF_MASK, 16'h0000);
    chk("irq_masked", 32'h0, 32'(irq));
    wrok(OFF_MASK, 16'h0001);
    chk("irq_unmasked", 32'h1, 32'(irq));
    wrok(OFF_STATUS, 16'h0001);
    chk("irq_cleared", 32'h0, 32'(irq));
    end_of_test();
  end
endmodule
`default_nettype wire

/* sim/tcto_slave_model.sv */
// Cascaded slave timer that watches the trigger output.
// Assumes the trigger output is a registered level on the same clock.
`timescale 1ns/1ps
`default_nettype none
module tcto_slave_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic trigger_output,
  output var int edges
);
  logic last_reg;
  // A slave in trigger operation starts once per rising edge it sees
  always @(posedge clk_sys) begin
    if (rst) begin
      last_reg <= 1'b0;
      edges <= 0;
    end else begin
      last_reg <= trigger_output;
      if (trigger_output && !last_reg) edges <= edges + 1;
    end
  end
endmodule
`default_nettype wire
